// >>> rtl/rst_boot_pkg.sv
// Package with register map, field positions and timing for the reset and boot-pin block
package rst_boot_pkg;
   localparam logic [3:0] ADDR_PUDR = 4'h0;     // Pull-up disable register
   localparam logic [3:0] ADDR_MODE = 4'h4;     // Operating mode register
   localparam logic [3:0] ADDR_STAT = 4'h8;     // Reset status register
   localparam int PUDR_RST_BIT = 0;             // Reset pin pull-up off
   localparam int PUDR_BOOTPIN_BIT = 1;         // External boot pin pull-up off
   localparam int PUDR_MEMMODE_BIT = 2;         // Memory mode pin pull-up off
   localparam int PUDR_W = 3;                   // Implemented pull-up bits
   localparam int MODE_SRC_BIT = 0;             // Boot source bit
   localparam int MODE_SEC_BIT = 1;             // Flash secured bit
   localparam int STAT_POR_BIT = 0;             // Power-on reset seen
   localparam int STAT_EXT_BIT = 1;             // External reset seen
   localparam logic [PUDR_W-1:0] PUDR_RESET = 3'h0; // Pull-ups on after reset
   localparam logic [1:0] RESP_OKAY = 2'h0;     // AXI okay
   localparam logic [1:0] RESP_SLVERR = 2'h2;   // AXI slave error
   localparam int RELEASE_CYCLES_DEF = 64;      // Default release count
   localparam int POR_CYCLES_DEF = 16;          // Default power-on stretch
   localparam int CNT_W = 16;                   // Release counter width
endpackage

// >>> rtl/rst_release.sv
// Reset release counter: holds reset, then releases in step with clock
module rst_release
   import rst_boot_pkg::*;
#(
   parameter logic [CNT_W-1:0] RELEASE_CYCLES = CNT_W'(RELEASE_CYCLES_DEF)
) (
   input wire logic clk, // Internal clock
   input wire logic hold, // Reset request, high holds
   output logic rst_active // Registered internal reset, high active
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt; // Cycles since request dropped
      logic active;          // Internal reset state
   } rel_state_t;
   rel_state_t st_reg, st_next;

   // Count up after request drops; any request restarts the wait
   always_comb begin
      st_next = st_reg;
      if (hold) begin
         st_next.cnt = '0;
         st_next.active = 1'b1;
      end else if (st_reg.active) begin
         if (st_reg.cnt == RELEASE_CYCLES - CNT_W'(1)) begin
            st_next.active = 1'b0;
         end else begin
            st_next.cnt = st_reg.cnt + CNT_W'(1);
         end
      end
   end

   // No reset of its own: the hold input is the reset, so no X-release hazard
   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end
   assign rst_active = st_reg.active;

   property p_hold_active;
      @(posedge clk) hold |=> rst_active;
   endproperty
   a_hold_active: assert property (p_hold_active) else $error("reset not held");
   property p_no_early;
      @(posedge clk) $fell(hold) |=> rst_active [*2];
   endproperty
   a_no_early: assert property (p_no_early) else $error("reset released early");
endmodule

// >>> rtl/por_gen.sv
// Power-on reset pulse generator, independent of the external reset pin
module por_gen
   import rst_boot_pkg::*;
#(
   parameter logic [CNT_W-1:0] POR_CYCLES = CNT_W'(POR_CYCLES_DEF)
) (
   input wire logic clk, // Internal clock
   input wire logic por_n, // Supply-good from the analog cell, low at power-up
   output logic por_active // High while power-on reset lasts
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt; // Stretch counter
      logic active;          // Power-on reset state
   } por_state_t;
   por_state_t st_reg, st_next;

   // Stretch the supply-good edge so the core sees a clean pulse
   always_comb begin
      st_next = st_reg;
      if (!por_n) begin
         st_next.cnt = '0;
         st_next.active = 1'b1;
      end else if (st_reg.cnt == POR_CYCLES) begin
         st_next.active = 1'b0;
      end else begin
         st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
   end
   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end
   assign por_active = st_reg.active;

   property p_por;
      @(posedge clk) !por_n |=> por_active;
   endproperty
   a_por: assert property (p_por) else $error("power-on reset missed");
endmodule

// >>> rtl/rst_boot_ctrl.sv
// Top of the reset and boot-pin block with AXI4-Lite register access
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
module rst_boot_ctrl
   import rst_boot_pkg::*;
#(
   parameter logic [CNT_W-1:0] RELEASE_CYCLES = CNT_W'(RELEASE_CYCLES_DEF), // Release count
   parameter logic [CNT_W-1:0] POR_CYCLES = CNT_W'(POR_CYCLES_DEF) // Power-on stretch
) (
   input wire logic aclk, // 40 MHz clock
   input wire logic aresetn, // Bus reset, active low
   input wire logic por_n, // Supply good, low at power-up
   input wire logic ext_reset_n, // External reset pin, active low
   input wire logic trst_n, // Debug port reset, active low
   input wire logic flash_secure_n, // Low when flash is secured
   input wire logic [3:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [3:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic reset_state_output, // Follows internal reset, high active
   output logic core_reset_n, // Core reset, active low
   output logic debug_reset_n, // Debug module reset, active low
   output logic reset_pullup_en, // Pull-up enable on reset pin
   output logic boot_pin_pullup_en, // Pull-up enable on external boot pin
   output logic memmode_pullup_en, // Pull-up enable on memory mode pin
   output logic boot_source_bit, // Boot source, 1 = external
   output logic flash_secured_bit // 1 = flash not secured
);
   // Boot selects are tied low inside the package, so they are constants here
   localparam logic external_boot_select = 1'b0;
   localparam logic ext_memory_boot_select = 1'b0;

   typedef struct packed {
      logic aw_got;            // Write address latched
      logic w_got;             // Write data latched
      logic [3:0] awaddr;      // Latched write address
      logic [31:0] wdata;      // Latched write data
      logic [3:0] wstrb;       // Latched strobes
      logic bvalid;            // Write response pending
      logic [1:0] bresp;       // Write response code
      logic rvalid;            // Read data pending
      logic [31:0] rdata;      // Read data
      logic [1:0] rresp;       // Read response code
      logic [PUDR_W-1:0] pullup_disable_reg; // Pull-up disable bits
      logic [1:0] operating_mode_reg; // Mode bits, source and secured
      logic por_seen;          // Sticky power-on reset cause
      logic ext_seen;          // Sticky external reset cause
      logic rst_out;           // Registered reset output
      logic dbg_rst_n;         // Registered debug reset, active low
      logic was_rst;           // Reset active last cycle
      logic awready; // Registered write address ready
      logic wready; // Registered write data ready
      logic arready; // Registered read address ready
      logic core_rst_n; // Registered core reset, active low
      logic [PUDR_W-1:0] pu_en; // Registered pull-up enables
   } top_state_t;
   top_state_t st_reg, st_next;

   logic por_active; // Power-on reset from generator
   logic rst_active; // Internal reset after release counter
   logic hold; // Power-on or external pin reset asserted

   // Either reset source holds the chip; external pin acts directly
   assign hold = por_active | ~ext_reset_n;

   por_gen #(.POR_CYCLES(POR_CYCLES)) u_por (
      .clk(aclk),
      .por_n(por_n),
      .por_active(por_active)
   );

   rst_release #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_rel (
      .clk(aclk),
      .hold(hold),
      .rst_active(rst_active)
   );

   // Resolve boot mode: external boot only with flash unsecured
   function automatic logic [1:0] boot_mode(input logic ext_sel, input logic unsecured);
      logic [1:0] m;
      m = '0;
      m[MODE_SEC_BIT] = unsecured;
      m[MODE_SRC_BIT] = ext_sel & unsecured;
      return m;
   endfunction

   // Merge a write word into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Read word of the pull-up disable register
   function automatic logic [31:0] read_word(input top_state_t s);
      logic [31:0] r;
      r = '0;
      r[PUDR_W-1:0] = s.pullup_disable_reg;
      return r;
   endfunction

   // Next-state logic: bus slave, pull-up bits, mode capture, reset outputs
   always_comb begin
      logic [31:0] m;
      logic [31:0] rd;
      m = '0;
      rd = '0;
      st_next = st_reg;
      st_next.was_rst = rst_active;
      st_next.rst_out = rst_active | hold;
      // Debug logic reset only by its own pin, so a chip reset leaves it alone
      st_next.dbg_rst_n = trst_n;
      if (por_active) begin
         st_next.por_seen = 1'b1;
      end
      if (~ext_reset_n) begin
         st_next.ext_seen = 1'b1;
      end
      if (rst_active) begin
         // Pull-ups forced on while in reset
         st_next.pullup_disable_reg = PUDR_RESET;
         // Mode latched at reset; secured flash forces internal boot
         st_next.operating_mode_reg = boot_mode(external_boot_select, flash_secure_n);
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b0;
         st_next.rvalid = 1'b0;
      end else begin
         // Accept write address and data in either order
         if (s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
         end
         if (s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
         end
         if (st_reg.aw_got && st_reg.w_got) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            unique case (st_reg.awaddr)
               ADDR_PUDR: begin
                  m = merge({{(32-PUDR_W){1'b0}}, st_reg.pullup_disable_reg}, st_reg.wdata, st_reg.wstrb);
                  st_next.pullup_disable_reg = m[PUDR_W-1:0];
               end
               ADDR_MODE: begin
                  // Only the source bit may change after reset; secured bit fixed
                  if (st_reg.wstrb[0]) begin
                     st_next.operating_mode_reg[MODE_SRC_BIT] = st_reg.wdata[MODE_SRC_BIT];
                  end
               end
               ADDR_STAT: begin
                  // Write one to clear cause bits; a new cause wins
                  if (st_reg.wstrb[0] && st_reg.wdata[STAT_POR_BIT] && !por_active) begin
                     st_next.por_seen = 1'b0;
                  end
                  if (st_reg.wstrb[0] && st_reg.wdata[STAT_EXT_BIT] && ext_reset_n) begin
                     st_next.ext_seen = 1'b0;
                  end
               end
               default: begin
                  st_next.bresp = RESP_SLVERR;
               end
            endcase
         end
         if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
         end
         // Reads answer one cycle after the address is taken
         if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
               ADDR_PUDR: rd = read_word(st_reg);
               ADDR_MODE: rd[1:0] = st_reg.operating_mode_reg;
               ADDR_STAT: begin
                  rd[STAT_POR_BIT] = st_reg.por_seen;
                  rd[STAT_EXT_BIT] = st_reg.ext_seen;
               end
               default: st_next.rresp = RESP_SLVERR;
            endcase
            st_next.rdata = rd;
         end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
         end
      end
      // Pin-facing levels registered so no output sees a gate glitch
      st_next.awready = !st_next.aw_got && !st_next.bvalid && !st_next.rst_out;
      st_next.wready = !st_next.w_got && !st_next.bvalid && !st_next.rst_out;
      st_next.arready = !st_next.rvalid && !st_next.rst_out;
      st_next.core_rst_n = ~st_next.rst_out;
      st_next.pu_en = ~st_next.pullup_disable_reg;
   end

   // Single register stage; bus reset clears all state, then sets reset output, reset-last-cycle flag, power-on cause, debug reset and pull-up enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
         st_reg.rst_out <= 1'b1;
         st_reg.was_rst <= 1'b1;
         st_reg.por_seen <= 1'b1;
         st_reg.dbg_rst_n <= 1'b1;
         st_reg.pu_en <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign reset_state_output = st_reg.rst_out;
   assign core_reset_n = st_reg.core_rst_n;
   assign debug_reset_n = st_reg.dbg_rst_n;
   assign reset_pullup_en = st_reg.pu_en[PUDR_RST_BIT];
   assign boot_pin_pullup_en = st_reg.pu_en[PUDR_BOOTPIN_BIT];
   assign memmode_pullup_en = st_reg.pu_en[PUDR_MEMMODE_BIT];
   assign boot_source_bit = st_reg.operating_mode_reg[MODE_SRC_BIT];
   assign flash_secured_bit = st_reg.operating_mode_reg[MODE_SEC_BIT];

   property p_rst_out;
      @(posedge aclk) disable iff (!aresetn) !ext_reset_n |=> reset_state_output;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset output low during pin reset");

   property p_secure;
      @(posedge aclk) disable iff (!aresetn) (rst_active && !flash_secure_n) |=> !boot_source_bit;
   endproperty
   a_secure: assert property (p_secure) else $error("external boot with secured flash");

   property p_internal;
      @(posedge aclk) disable iff (!aresetn) rst_active |=> !boot_source_bit;
   endproperty
   a_internal: assert property (p_internal) else $error("tied-low boot select not internal");

   property p_pullups;
      @(posedge aclk) disable iff (!aresetn) rst_active |=> (reset_pullup_en && boot_pin_pullup_en && memmode_pullup_en);
   endproperty
   a_pullups: assert property (p_pullups) else $error("pull-up off during reset");

   property p_debug;
      @(posedge aclk) disable iff (!aresetn) (trst_n && !ext_reset_n) |=> debug_reset_n;
   endproperty
   a_debug: assert property (p_debug) else $error("debug reset by chip reset");

   property p_pudr_write;
      @(posedge aclk) disable iff (!aresetn)
         (st_reg.aw_got && st_reg.w_got && st_reg.awaddr == ADDR_PUDR && st_reg.wstrb[0] && !rst_active)
         |=> reset_pullup_en == !$past(st_reg.wdata[PUDR_RST_BIT]);
   endproperty
   a_pudr_write: assert property (p_pudr_write) else $error("reset pull-up write lost");

   property p_read_lat;
      @(posedge aclk) disable iff (!aresetn) (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer late");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn) $fell(ext_reset_n) |=> reset_state_output [*2];
   endproperty
   a_hold: assert property (p_hold) else $error("reset not held");

   property p_core_follow;
      @(posedge aclk) disable iff (!aresetn) core_reset_n != reset_state_output;
   endproperty
   a_core_follow: assert property (p_core_follow) else $error("core reset disagrees with reset output");

   property p_trst_only;
      @(posedge aclk) disable iff (!aresetn) !trst_n |=> !debug_reset_n;
   endproperty
   a_trst_only: assert property (p_trst_only) else $error("debug reset missed its pin");

   property p_release_out;
      @(posedge aclk) disable iff (!aresetn) ($fell(rst_active) && !hold) |=> !reset_state_output;
   endproperty
   a_release_out: assert property (p_release_out) else $error("reset output late after release");

   property p_bus_quiet;
      @(posedge aclk) disable iff (!aresetn) reset_state_output |-> !(s_axi_awready || s_axi_wready || s_axi_arready);
   endproperty
   a_bus_quiet: assert property (p_bus_quiet) else $error("bus ready during reset");
endmodule

// >>> tb/board_model.sv
// Board-side model: supply monitor, reset button, debug probe and flash lock strap
module board_model (
   input wire logic clk, // Bench clock
   output logic por_n, // Supply good, low at power-up
   output logic ext_reset_n, // Reset button, active low
   output logic trst_n, // Probe debug reset, active low
   output logic flash_secure_n // Low when flash is locked
);
   timeunit 1ns;
   timeprecision 100ps;

   // Supply starts low so that the power-on reset runs first
   initial begin
      por_n = 1'b0;
      ext_reset_n = 1'b1;
      trst_n = 1'b1;
      flash_secure_n = 1'b1;
   end

   // Supply turns good after n cycles; a slow supply is a larger n
   task automatic supply_good(input int n);
      repeat (n) @(posedge clk);
      por_n <= 1'b1;
   endtask

   // Press the button; with_debug also resets the probe side
   task automatic press(input logic with_debug);
      @(posedge clk);
      ext_reset_n <= 1'b0;
      trst_n <= ~with_debug;
   endtask

   // Both lines are let go together, never one left behind
   task automatic release_btn();
      @(posedge clk);
      ext_reset_n <= 1'b1;
      trst_n <= 1'b1;
   endtask

   // Flash lock strap, only changed outside of reset
   task automatic lock_flash(input logic locked);
      @(posedge clk);
      flash_secure_n <= ~locked;
   endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the reset and boot-pin block
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import rst_boot_pkg::*;
   localparam logic [CNT_W-1:0] REL = 16'h0004; // Short release count keeps the run brief
   localparam logic [CNT_W-1:0] PORC = 16'h0002; // Short power-on stretch
   localparam logic [3:0] ADDR_BAD = 4'hC; // Nothing lives here
   logic aclk, aresetn, por_n, ext_reset_n, trst_n, flash_secure_n;
   logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic reset_state_output, core_reset_n, debug_reset_n, boot_source_bit, flash_secured_bit;
   logic reset_pullup_en, boot_pin_pullup_en, memmode_pullup_en;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   int n;

   board_model u_board (.clk(aclk), .por_n(por_n), .ext_reset_n(ext_reset_n), .trst_n(trst_n),
      .flash_secure_n(flash_secure_n));

   rst_boot_ctrl #(.RELEASE_CYCLES(REL), .POR_CYCLES(PORC)) DUT (.aclk(aclk), .aresetn(aresetn),
      .por_n(por_n), .ext_reset_n(ext_reset_n), .trst_n(trst_n), .flash_secure_n(flash_secure_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .reset_state_output(reset_state_output),
      .core_reset_n(core_reset_n), .debug_reset_n(debug_reset_n), .reset_pullup_en(reset_pullup_en),
      .boot_pin_pullup_en(boot_pin_pullup_en), .memmode_pullup_en(memmode_pullup_en),
      .boot_source_bit(boot_source_bit), .flash_secured_bit(flash_secured_bit));

   // Free-running 40 MHz clock
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // Verdict and end of run, reached from the sequence or the watchdog
   task automatic test_done();
      if (err_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog: whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         test_done();
      end
   end

   // Write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_pend, w_pend;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_pend = 1'b1;
      w_pend = 1'b1;
      forever begin
         @(posedge aclk);
         if (aw_pend && s_axi_awready === 1'b1) begin
            aw_pend = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_pend && s_axi_wready === 1'b1) begin
            w_pend = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   // Read: address held until taken, data taken with rvalid
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_pend;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ar_pend = 1'b1;
      forever begin
         @(posedge aclk);
         if (ar_pend && s_axi_arready === 1'b1) begin
            ar_pend = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   // Write expecting an okay answer
   task automatic wr_ok(input logic [3:0] a, input logic [31:0] d);
      axi_wr(a, d, resp);
      `CHK("bresp", RESP_OKAY, resp)
   endtask

   // Read expecting an okay answer and the given word
   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      axi_rd(a, rd, resp);
      `CHK("rresp", RESP_OKAY, resp)
      `CHK(nm, exp, rd)
   endtask

   // Count edges until the internal reset lets go
   task automatic wait_rel();
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (reset_state_output !== 1'b0);
   endtask

   // Main sequence
   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK("reset out at power-up", 1'b1, reset_state_output)
      u_board.supply_good(2);
      wait_rel();
      `CHK("core reset after release", 1'b1, core_reset_n)
      `CHK("pull-ups after power-up", 3'b111, {memmode_pullup_en, boot_pin_pullup_en, reset_pullup_en})
      `CHK("boot source", 1'b0, boot_source_bit)
      `CHK("flash state out", 1'b1, flash_secured_bit)
      rd_chk("status power-on", ADDR_STAT, 32'h0000_0001);
      wr_ok(ADDR_STAT, 32'h0000_0003);
      rd_chk("status cleared", ADDR_STAT, 32'h0000_0000);
      rd_chk("mode unsecured", ADDR_MODE, 32'h0000_0002);
      // Pull-ups dropped one by one, each bit steering its own pin
      for (int i = 0; i < PUDR_W; i++) begin
         wr_ok(ADDR_PUDR, 32'((1 << (i + 1)) - 1));
         `CHK("pull-up enables", 3'(~((1 << (i + 1)) - 1)), {memmode_pullup_en, boot_pin_pullup_en, reset_pullup_en})
      end
      rd_chk("pull-up disable", ADDR_PUDR, 32'h0000_0007);
      axi_rd(ADDR_BAD, rd, resp);
      `CHK("unmapped read", RESP_SLVERR, resp)
      axi_wr(ADDR_BAD, 32'h0000_0001, resp);
      `CHK("unmapped write", RESP_SLVERR, resp)
      // Button reset with flash locked, probe left alone
      u_board.lock_flash(1'b1);
      u_board.press(1'b0);
      repeat (3) @(posedge aclk);
      `CHK("reset out held", 1'b1, reset_state_output)
      `CHK("core reset held", 1'b0, core_reset_n)
      `CHK("debug kept", 1'b1, debug_reset_n)
      `CHK("pull-ups in reset", 3'b111, {memmode_pullup_en, boot_pin_pullup_en, reset_pullup_en})
      u_board.release_btn();
      wait_rel();
      `CHK("release count", 1'b1, (n >= REL && n <= REL + 3))
      `CHK("debug kept after", 1'b1, debug_reset_n)
      rd_chk("mode secured", ADDR_MODE, 32'h0000_0000);
      `CHK("boot source secured", 1'b0, boot_source_bit)
      `CHK("flash state secured", 1'b0, flash_secured_bit)
      axi_rd(ADDR_STAT, rd, resp);
      `CHK("status ext seen", 1'b1, rd[STAT_EXT_BIT])
      rd_chk("pull-up disable cleared", ADDR_PUDR, 32'h0000_0000);
      // Full reset: button and probe together
      u_board.lock_flash(1'b0);
      u_board.press(1'b1);
      repeat (3) @(posedge aclk);
      `CHK("debug reset", 1'b0, debug_reset_n)
      `CHK("reset out full", 1'b1, reset_state_output)
      u_board.release_btn();
      wait_rel();
      `CHK("release count full", 1'b1, (n >= REL && n <= REL + 3))
      `CHK("debug released", 1'b1, debug_reset_n)
      rd_chk("mode unlocked", ADDR_MODE, 32'h0000_0002);
      `CHK("boot source final", 1'b0, boot_source_bit)
      test_done();
   end
endmodule
